// [logic/dvs_pkg.sv]
// shared constants and carriers for the buck setting selector
package dvs_pkg;
   localparam int          NUM_BUCKS     = 4;
   localparam int          NUM_SETTINGS  = 4;
   localparam int          CODE_W        = 10;
   localparam int          HIGH_W        = 8;
   localparam int          LOW_W         = 2;
   localparam int          IDX_W         = 2;
   localparam logic [0:0]  SRC_REGISTER  = 1'h0;
   localparam logic [0:0]  SRC_PINS      = 1'h1;
   localparam logic [3:0]  MAP_SPI_SCALE = 4'h3;
   localparam logic [1:0]  ASSIGN_PIN_A  = 2'h0;
   localparam logic [1:0]  ASSIGN_PIN_B  = 2'h1;
   localparam logic [1:0]  ASSIGN_REG    = 2'h3;
   localparam logic [9:0]  CODE_TOP      = 10'h3E5;
   localparam logic [9:0]  CODE_RESET    = 10'h000;
   localparam logic [1:0]  INDEX_RESET   = 2'h0;
   // step size in microvolts for divider ratios 1.0, 0.8, 0.6
   localparam int          STEP_UV_DIV10 = 1200;
   localparam int          STEP_UV_DIV08 = 1500;
   localparam int          STEP_UV_DIV06 = 2000;

   typedef struct packed {
      logic       wr_high;
      logic       wr_low;
      logic [1:0] buck;
      logic [1:0] setting;
      logic [7:0] data;
   } code_write_t;

   typedef struct packed {
      logic [1:0] index;
      logic       source;
      logic [1:0] pin_assign;
   } buck_cfg_t;
endpackage : dvs_pkg

// [logic/pin_sync.sv]
// two-flop synchroniser for the scaling pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] pin_out
);
   logic [WIDTH-1:0] first_reg;
   logic [WIDTH-1:0] first_next;
   logic [WIDTH-1:0] second_next;

   always_comb begin
      first_next  = pin_in;
      second_next = first_reg;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         first_reg <= '0;
         pin_out   <= '0;
      end else begin
         first_reg <= first_next;
         pin_out   <= second_next;
      end
   end
endmodule : pin_sync
`default_nettype wire

// [logic/buck_dvs_setting_select.sv]
// per-buck active voltage setting selection and staged code storage
// Contract
// - each buck keeps four settings; one active setting drives its target code
// - source bit 0 picks by register index, 1 picks by scaling pin
// - two-bit register index codes 0..3 select settings zero to three
// - each setting is ten bits: eight high bits plus two low bits
// - high byte write is staged; code changes only when low bits written
// - code maps linearly to volts; step fixed by feedback divider ratio
// - map 0x3 turns general pins 0 and 1 into scaling pins A and B
// - pin assign field binds each buck to pin A or B
// - in pin mode active setting follows assigned pin level
// - pin assign value 0x3 falls back to the register index
`timescale 1ns/1ns
`default_nettype none
module buck_dvs_setting_select #(
   parameter int NB = dvs_pkg::NUM_BUCKS
) (
   input  wire logic                                 clk,
   input  wire logic                                 rstn,
   input  wire dvs_pkg::code_write_t                 code_wr,
   input  wire dvs_pkg::buck_cfg_t [NB-1:0]          buck_cfg,
   input  wire logic [3:0]                           io_function_map,
   input  wire logic                                 general_pin_0,
   input  wire logic                                 general_pin_1,
   output var  logic [NB-1:0][1:0]                   active_index,
   output var  logic [NB-1:0][dvs_pkg::CODE_W-1:0]   active_code
);
   logic [NB-1:0][3:0][dvs_pkg::CODE_W-1:0] code_reg;
   logic [NB-1:0][3:0][dvs_pkg::CODE_W-1:0] code_next;
   logic [NB-1:0][3:0][dvs_pkg::HIGH_W-1:0] stage_reg;
   logic [NB-1:0][3:0][dvs_pkg::HIGH_W-1:0] stage_next;
   logic [NB-1:0][1:0]                      index_next;
   logic [NB-1:0][dvs_pkg::CODE_W-1:0]      out_next;
   logic [1:0]                              pins_sync;
   logic                                    scaling_pin_a;
   logic                                    scaling_pin_b;

   // synchronised pin pair, read only after the second flop
   pin_sync #(.WIDTH(2)) u_sync (
      .clk     (clk),
      .rstn    (rstn),
      .pin_in  ({general_pin_1, general_pin_0}),
      .pin_out (pins_sync)
   );

   // pin A/B exist only in map 0x3
   function automatic logic pin_active(input logic [3:0] map);
      return map == dvs_pkg::MAP_SPI_SCALE;
   endfunction : pin_active

   assign scaling_pin_a = pins_sync[0];
   assign scaling_pin_b = pins_sync[1];

   // pick the active setting of one buck
   function automatic logic [1:0] pick_index(input dvs_pkg::buck_cfg_t cfg,
                                             input logic [3:0] map,
                                             input logic pa,
                                             input logic pb);
      logic [1:0] idx;
      idx = cfg.index;
      if (cfg.source == dvs_pkg::SRC_PINS && pin_active(map)) begin
         case (cfg.pin_assign)
            dvs_pkg::ASSIGN_PIN_A: idx = {1'b0, pa};
            dvs_pkg::ASSIGN_PIN_B: idx = {1'b0, pb};
            dvs_pkg::ASSIGN_REG:   idx = cfg.index;
            default:               idx = cfg.index;
         endcase
      end
      return idx;
   endfunction : pick_index

   always_comb begin
      code_next  = code_reg;
      stage_next = stage_reg;
      if (code_wr.wr_high) begin
         stage_next[code_wr.buck][code_wr.setting] = code_wr.data;
      end
      if (code_wr.wr_low) begin
         code_next[code_wr.buck][code_wr.setting] =
            {stage_next[code_wr.buck][code_wr.setting], code_wr.data[1:0]};
      end
   end

   always_comb begin
      for (int b = 0; b < NB; b++) begin
         index_next[b] = pick_index(buck_cfg[b], io_function_map,
                                    scaling_pin_a, scaling_pin_b);
         // linear code passes straight to the DAC target
         out_next[b]   = code_reg[b][index_next[b]];
      end
   end

   // storage group: staged high bytes and committed codes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         code_reg  <= {(NB*4){dvs_pkg::CODE_RESET}};
         stage_reg <= '0;
      end else begin
         code_reg  <= code_next;
         stage_reg <= stage_next;
      end
   end

   // output group: active index and code per buck
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         active_index <= {NB{dvs_pkg::INDEX_RESET}};
         active_code  <= {NB{dvs_pkg::CODE_RESET}};
      end else begin
         active_index <= index_next;
         active_code  <= out_next;
      end
   end

   staged_high_a: assert property (@(posedge clk) disable iff (!rstn)
      (code_wr.wr_high && !code_wr.wr_low) |=> $stable(code_reg))
      else $error("high byte write changed a stored code");

   low_commit_a: assert property (@(posedge clk) disable iff (!rstn)
      code_wr.wr_low |=> code_reg[$past(code_wr.buck)][$past(code_wr.setting)][1:0]
                         == $past(code_wr.data[1:0]))
      else $error("low bits not committed");

   reg_index_a: assert property (@(posedge clk) disable iff (!rstn)
      (buck_cfg[1].source == dvs_pkg::SRC_REGISTER) |=> active_index[1] == $past(buck_cfg[1].index))
      else $error("register index not followed");

   fallback_reg_a: assert property (@(posedge clk) disable iff (!rstn)
      (buck_cfg[2].pin_assign == dvs_pkg::ASSIGN_REG) |=> active_index[2] == $past(buck_cfg[2].index))
      else $error("assign 3 did not use register index");

   sequence pin_a_mode;
      buck_cfg[2].source == dvs_pkg::SRC_PINS && pin_active(io_function_map)
      && buck_cfg[2].pin_assign == dvs_pkg::ASSIGN_PIN_A;
   endsequence

   pin_follow_a: assert property (@(posedge clk) disable iff (!rstn)
      pin_a_mode |=> active_index[2] == {1'b0, $past(scaling_pin_a)})
      else $error("active index does not follow pin A");

   sync_delay_a: assert property (@(posedge clk) disable iff (!rstn)
      (pin_a_mode [*4]) |-> active_index[2][0] == $past(general_pin_0, 3))
      else $error("pin path is not three flops deep");

   code_out_a: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> active_code[1] == $past(code_reg[1][index_next[1]]))
      else $error("active code not the selected setting");

   no_map_a: assert property (@(posedge clk) disable iff (!rstn)
      (!pin_active(io_function_map)) |=> active_index[2] == $past(buck_cfg[2].index))
      else $error("pins used outside map 3");

   stage_load_a: assert property (@(posedge clk) disable iff (!rstn)
      code_wr.wr_high |=> stage_reg[$past(code_wr.buck)][$past(code_wr.setting)] == $past(code_wr.data))
      else $error("high byte not staged");

   code_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !code_wr.wr_low |=> $stable(code_reg))
      else $error("code changed without a low write");

   both_write_a: assert property (@(posedge clk) disable iff (!rstn)
      (code_wr.wr_high && code_wr.wr_low) |=> code_reg[$past(code_wr.buck)][$past(code_wr.setting)]
                                               == {$past(code_wr.data), $past(code_wr.data[1:0])})
      else $error("same cycle write did not use the fresh high byte");

   low_reuse_a: assert property (@(posedge clk) disable iff (!rstn)
      (code_wr.wr_low && !code_wr.wr_high)
      |=> code_reg[$past(code_wr.buck)][$past(code_wr.setting)][dvs_pkg::CODE_W-1:dvs_pkg::LOW_W]
          == $past(stage_reg[code_wr.buck][code_wr.setting]))
      else $error("low write did not reuse the staged high byte");

   // staged pair: high byte, then low bits to the same setting
   sequence high_stage_s;
      code_wr.wr_high && !code_wr.wr_low;
   endsequence

   sequence low_commit_s;
      code_wr.wr_low && !code_wr.wr_high
      && code_wr.buck == $past(code_wr.buck) && code_wr.setting == $past(code_wr.setting);
   endsequence

   pair_commit_a: assert property (@(posedge clk) disable iff (!rstn)
      high_stage_s ##1 low_commit_s |=> code_reg[$past(code_wr.buck)][$past(code_wr.setting)]
                                         == {$past(code_wr.data, 2), $past(code_wr.data[1:0])})
      else $error("staged pair not committed as one code");

   // pin B path mirrors pin A
   sequence pin_b_mode;
      buck_cfg[2].source == dvs_pkg::SRC_PINS && pin_active(io_function_map)
      && buck_cfg[2].pin_assign == dvs_pkg::ASSIGN_PIN_B;
   endsequence

   pin_b_follow_a: assert property (@(posedge clk) disable iff (!rstn)
      pin_b_mode |=> active_index[2] == {1'b0, $past(scaling_pin_b)})
      else $error("active index does not follow pin B");

   sync_b_delay_a: assert property (@(posedge clk) disable iff (!rstn)
      (pin_b_mode [*4]) |-> active_index[2][0] == $past(general_pin_1, 3))
      else $error("pin B path is not three flops deep");

   pin_low_half_a: assert property (@(posedge clk) disable iff (!rstn)
      (buck_cfg[2].source == dvs_pkg::SRC_PINS && pin_active(io_function_map)
       && (buck_cfg[2].pin_assign == dvs_pkg::ASSIGN_PIN_A || buck_cfg[2].pin_assign == dvs_pkg::ASSIGN_PIN_B))
      |=> active_index[2][1] == 1'b0)
      else $error("pin mode reached settings two or three");

   assign_other_a: assert property (@(posedge clk) disable iff (!rstn)
      (buck_cfg[2].pin_assign != dvs_pkg::ASSIGN_PIN_A && buck_cfg[2].pin_assign != dvs_pkg::ASSIGN_PIN_B)
      |=> active_index[2] == $past(buck_cfg[2].index))
      else $error("unbound pin assign did not use register index");

   // every buck: output matches its stored setting, register source and map gate hold
   for (genvar g = 0; g < NB; g++) begin : g_buck
      each_code_a: assert property (@(posedge clk) disable iff (!rstn)
         $stable(code_reg[g]) |-> active_code[g] == code_reg[g][active_index[g]])
         else $error("active code differs from selected setting");

      each_src_reg_a: assert property (@(posedge clk) disable iff (!rstn)
         (buck_cfg[g].source == dvs_pkg::SRC_REGISTER) |=> active_index[g] == $past(buck_cfg[g].index))
         else $error("register source not followed");

      each_map_gate_a: assert property (@(posedge clk) disable iff (!rstn)
         (!pin_active(io_function_map)) |=> active_index[g] == $past(buck_cfg[g].index))
         else $error("pins used outside their map");
   end : g_buck
endmodule : buck_dvs_setting_select
`default_nettype wire

// [dv/host_model.sv]
// host stand-in driving code writes, buck config and scaling pins
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input  wire logic                     clk,
   output var  dvs_pkg::code_write_t     code_wr,
   output var  dvs_pkg::buck_cfg_t [3:0] buck_cfg,
   output var  logic [3:0]               io_function_map,
   output var  logic                     general_pin_0,
   output var  logic                     general_pin_1
);
   initial begin
      code_wr = '0;
      buck_cfg = '0;
      io_function_map = 4'h0;
      general_pin_0 = 1'b0;
      general_pin_1 = 1'b0;
   end
   // high byte first, low bits commit; low may be skipped
   task automatic put_code(input logic [1:0] b, s, input logic [9:0] c, input bit low);
      @(negedge clk);
      code_wr = '{1'b1, 1'b0, b, s, c[9:2]};
      @(negedge clk);
      code_wr = '{1'b0, low, b, s, {6'h00, c[1:0]}};
      @(negedge clk);
      code_wr = '0;
   endtask : put_code
   // high and low in one cycle: the fresh high byte is taken
   task automatic put_same(input logic [1:0] b, s, input logic [7:0] d);
      @(negedge clk);
      code_wr = '{1'b1, 1'b1, b, s, d};
      @(negedge clk);
      code_wr = '0;
   endtask : put_same
   task automatic set_cfg(input int b, input logic [1:0] idx, input logic src, input logic [1:0] pa);
      @(negedge clk);
      buck_cfg[b] = '{idx, src, pa};
   endtask : set_cfg
   task automatic set_pins(input logic [3:0] map, input logic a, bb);
      @(negedge clk);
      io_function_map = map;
      general_pin_0 = a;
      general_pin_1 = bb;
   endtask : set_pins
endmodule : host_model
`default_nettype wire

// [dv/tb_buck_dvs_setting_select.sv]
// self-checking bench for the buck setting selector
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
   $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_buck_dvs_setting_select;
   logic                     clk;
   logic                     rstn;
   int                       bad_count;
   int                       n_tests;
   dvs_pkg::code_write_t     code_wr;
   dvs_pkg::buck_cfg_t [3:0] buck_cfg;
   logic [3:0]               io_function_map;
   logic                     general_pin_0;
   logic                     general_pin_1;
   logic [3:0][1:0]          active_index;
   logic [3:0][9:0]          active_code;
   host_model host_model_i (.clk(clk), .code_wr(code_wr), .buck_cfg(buck_cfg), .io_function_map(io_function_map),
      .general_pin_0(general_pin_0), .general_pin_1(general_pin_1));
   buck_dvs_setting_select buck_dvs_setting_select_i (.clk(clk), .rstn(rstn), .code_wr(code_wr),
      .buck_cfg(buck_cfg), .io_function_map(io_function_map), .general_pin_0(general_pin_0),
      .general_pin_1(general_pin_1), .active_index(active_index), .active_code(active_code));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic t_code;
      `CHK("reset code", 40'h0, active_code)
      host_model_i.put_code(2'h0, 2'h0, 10'h3E5, 1'b1);
      repeat (3) @(negedge clk);
      `CHK("code top", 10'h3E5, active_code[0])
      host_model_i.put_code(2'h0, 2'h0, 10'h004, 1'b0);
      repeat (4) @(negedge clk);
      `CHK("staged only", 10'h3E5, active_code[0])
      host_model_i.put_same(2'h0, 2'h0, 8'h5A);
      repeat (3) @(negedge clk);
      `CHK("same cycle", 10'h16A, active_code[0])
      $display("code test done");
   endtask : t_code
   task automatic t_index;
      for (int s = 1; s < 4; s++) host_model_i.put_code(2'h1, s[1:0], 10'h100 + 10'(s), 1'b1);
      for (int i = 0; i < 4; i++) begin
         host_model_i.set_cfg(1, i[1:0], 1'b0, 2'h0);
         repeat (3) @(negedge clk);
         `CHK("reg index", i[1:0], active_index[1])
         `CHK("reg code", (i == 0) ? 10'h000 : 10'h100 + 10'(i), active_code[1])
      end
      $display("index test done");
   endtask : t_index
   task automatic chk_pin(input logic [3:0] m, input logic a, bb, src, input logic [1:0] pa, exp);
      host_model_i.set_pins(m, a, bb);
      host_model_i.set_cfg(2, 2'h2, src, pa);
      repeat (5) @(negedge clk);
      `CHK("pin index", exp, active_index[2])
   endtask : chk_pin
   task automatic t_pins;
      host_model_i.put_code(2'h2, 2'h1, 10'h2AA, 1'b1);
      chk_pin(4'h3, 1'b1, 1'b0, 1'b1, 2'h0, 2'h1);
      `CHK("pin code", 10'h2AA, active_code[2])
      chk_pin(4'h3, 1'b1, 1'b0, 1'b1, 2'h1, 2'h0);
      chk_pin(4'h3, 1'b0, 1'b1, 1'b1, 2'h1, 2'h1);
      chk_pin(4'h3, 1'b1, 1'b1, 1'b1, 2'h3, 2'h2);
      chk_pin(4'h3, 1'b1, 1'b1, 1'b1, 2'h2, 2'h2);
      chk_pin(4'h3, 1'b1, 1'b1, 1'b0, 2'h0, 2'h2);
      chk_pin(4'h0, 1'b1, 1'b1, 1'b1, 2'h0, 2'h2);
      $display("pin test done");
   endtask : t_pins
   initial begin
      bad_count = 0;
      n_tests = 0;
      rstn = 1'b0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      t_code();
      t_index();
      t_pins();
      finish_test();
   end
   initial begin
      #20000;
      bad_count++;
      finish_test();
   end
endmodule : tb_buck_dvs_setting_select
`default_nettype wire
